// *** src/hpp_edge_det.sv ***
// Purpose: edge detection on the handshake lines
// Assumes: lines synchronous to i_clk
// Notes: previous levels reset high, the idle level of the strobe line; ack idles low
`timescale 1ns/10ps
module hpp_edge_det
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // lines and edges
  hpp_edge_if.det e
);

  typedef struct packed {
    logic [1:0] prev;
  } hpp_edge_state_t;

  hpp_edge_state_t st_r;
  hpp_edge_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = e.lvl;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_r <= '{prev: hpp_pkg::RST_LEVELS};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_lane
      assign e.rise[g] = e.lvl[g] & ~st_r.prev[g];
      assign e.fall[g] = ~e.lvl[g] & st_r.prev[g];
    end
  endgenerate

endmodule : hpp_edge_det

// *** src/hpp_edge_if.sv ***
// Purpose: carries handshake line levels and their edges between modules
// Assumes: one clock domain
// Notes: edges are one-cycle pulses
`timescale 1ns/10ps
interface hpp_edge_if;
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;

  modport det
  (
    input lvl,
    output rise,
    output fall
  );

  modport use_edges
  (
    output lvl,
    input rise,
    input fall
  );
endinterface : hpp_edge_if

// *** src/hpp_pkg.sv ***
// Purpose: shared constants and state type for the handshake parallel port
// Assumes: host register offsets as seen on the 4-bit port address
// Notes: data offset is shared by the input and output latches
package hpp_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // host register offsets
  localparam logic [3:0] OFS_DATA = 4'hc;
  localparam logic [3:0] OFS_STATUS = 4'hd;

  // status field positions
  localparam int unsigned ST_OUT_FREE = 0;
  localparam int unsigned ST_IN_AVAIL = 1;
  localparam int unsigned ST_ACK = 2;
  localparam int unsigned ST_STROBE = 3;

  // values after reset, and the byte read at unmapped offsets
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_IN_AVAIL = 1'b0;
  localparam logic RST_IN_READY_N = 1'b0;
  localparam logic RST_DAV_N = 1'b1;
  localparam logic RST_DRV_EN = 1'b0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // edge detector lanes
  localparam int unsigned EDGE_N = 2;
  localparam int unsigned LANE_STROBE = 0;
  localparam int unsigned LANE_ACK = 1;
  localparam logic [1:0] RST_LEVELS = 2'h3;

  typedef struct packed {
    logic [7:0] in_latch;
    logic in_avail;
    logic in_ready_n;
    logic rd_data;
    logic wr_data;
    logic [7:0] out_latch;
    logic dav_n;
    logic drv_en;
    logic [7:0] rdata;
  } hpp_state_t;

endpackage : hpp_pkg

// *** src/hpp_port.sv ***
// Purpose: latched 8-bit parallel input and output port with handshaking
// Assumes: host strobes i_rd and i_wr are levels held for a whole access,
//   with i_addr stable while either is high; all inputs synchronous
// Notes: read data appears on o_rdata one cycle after the read is seen
//
// Overview of operation
// - data read returns input latch, ready goes high
// - status bit 1 shows input data available
// - status bit 3 mirrors the input strobe
// - input ready low only when port accepts
// - latch follows lines while strobe high
// - strobe fall captures, refuses, sets available
// - end of data read lowers ready
// - transparent mode: live data, ready high reading
// - data write loads latch, asserts data valid
// - status bit 0 shows output latch free
// - status bit 2 reflects acknowledge input
// - data valid active low; peripheral raises ack
// - acknowledge falling edge deasserts data valid
// - drivers always on or only ack high
// - data valid asserts at write end
// - direct mode: data valid pulses during write
// - bidirectional: drivers only during ack high
// - eight bit input and output paths
`timescale 1ns/10ps
module hpp_port
#(
  parameter int unsigned DATA_W = hpp_pkg::DATA_W,
  parameter int unsigned ADDR_W = hpp_pkg::ADDR_W
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,

  // host register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0] o_rdata,

  // parallel input side
  input wire logic [DATA_W-1:0] i_input_data_lines,
  input wire logic i_input_latch_strobe_n,
  output logic o_input_ready_n,

  // parallel output side
  output logic [DATA_W-1:0] o_output_data_lines,
  output logic o_output_drive_en,
  output logic o_output_data_valid_n,
  input wire logic i_ack_n,

  // driver enable option: high keeps drivers on
  input wire logic i_drive_always
);

  hpp_pkg::hpp_state_t st_r;
  hpp_pkg::hpp_state_t st_nxt;

  hpp_edge_if edges();

  logic sel_data;
  logic sel_status;
  logic rd_data_now;
  logic wr_data_now;
  logic rd_data_end;
  logic wr_data_end;
  logic strobe_fall;
  logic ack_fall;
  logic [DATA_W-1:0] status_val;

  assign edges.lvl[hpp_pkg::LANE_STROBE] = i_input_latch_strobe_n;
  assign edges.lvl[hpp_pkg::LANE_ACK] = i_ack_n;

  hpp_edge_det u_edge
  (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .e(edges)
  );

  assign strobe_fall = edges.fall[hpp_pkg::LANE_STROBE];
  assign ack_fall = edges.fall[hpp_pkg::LANE_ACK];

  // address decode
  always_comb
  begin
    sel_data = 1'b0;
    sel_status = 1'b0;
    if (i_addr == ADDR_W'(hpp_pkg::OFS_DATA))
    begin
      sel_data = 1'b1;
    end
    else if (i_addr == ADDR_W'(hpp_pkg::OFS_STATUS))
    begin
      sel_status = 1'b1;
    end
  end

  // a read and a write at once is not a legal host cycle; read is ignored
  assign rd_data_now = i_rd & ~i_wr & sel_data;
  assign wr_data_now = i_wr & sel_data;
  assign rd_data_end = st_r.rd_data & ~rd_data_now;
  assign wr_data_end = st_r.wr_data & ~wr_data_now;

  // status byte; unused bits read zero
  always_comb
  begin
    status_val = '0;
    status_val[hpp_pkg::ST_OUT_FREE] = st_r.dav_n;
    status_val[hpp_pkg::ST_IN_AVAIL] = st_r.in_avail;
    status_val[hpp_pkg::ST_ACK] = i_ack_n;
    status_val[hpp_pkg::ST_STROBE] = i_input_latch_strobe_n;
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rd_data = rd_data_now;
    st_nxt.wr_data = wr_data_now;

    // input latch: open while strobe is high, held while low
    if (i_input_latch_strobe_n)
    begin
      st_nxt.in_latch = i_input_data_lines;
    end

    // available flag: a strobe fall in the same cycle as a read end wins
    if (strobe_fall)
    begin
      st_nxt.in_avail = 1'b1;
    end
    else if (rd_data_end)
    begin
      st_nxt.in_avail = 1'b0;
    end

    // ready refuses data while a byte waits or the host is reading;
    // in transparent mode the flag never sets, so only the read counts
    st_nxt.in_ready_n = st_nxt.in_avail | rd_data_now;

    // output latch and data valid
    if (wr_data_now)
    begin
      st_nxt.out_latch = i_wdata;
      // high for the whole write gives the strobe pulse in direct mode
      st_nxt.dav_n = 1'b1;
    end
    else if (wr_data_end)
    begin
      st_nxt.dav_n = 1'b0;
    end
    else if (ack_fall)
    begin
      st_nxt.dav_n = 1'b1;
    end

    // drivers: forced on by the option, else only in the ack-high window
    st_nxt.drv_en = i_drive_always | i_ack_n;

    // read data
    if (i_rd & ~i_wr)
    begin
      if (sel_data)
      begin
        st_nxt.rdata = st_r.in_latch;
      end
      else if (sel_status)
      begin
        st_nxt.rdata = status_val;
      end
      else
      begin
        st_nxt.rdata = hpp_pkg::UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_r <= '{
        in_latch: hpp_pkg::RST_BYTE,
        in_avail: hpp_pkg::RST_IN_AVAIL,
        in_ready_n: hpp_pkg::RST_IN_READY_N,
        rd_data: 1'b0,
        wr_data: 1'b0,
        out_latch: hpp_pkg::RST_BYTE,
        dav_n: hpp_pkg::RST_DAV_N,
        drv_en: hpp_pkg::RST_DRV_EN,
        rdata: hpp_pkg::RST_BYTE
      };
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // every output straight from the state register
  assign o_rdata = st_r.rdata;
  assign o_input_ready_n = st_r.in_ready_n;
  assign o_output_data_lines = st_r.out_latch;
  assign o_output_drive_en = st_r.drv_en;
  assign o_output_data_valid_n = st_r.dav_n;

endmodule : hpp_port

// *** tb/hpp_periph.sv ***
// Purpose: peripheral on the far side of the parallel port
// Assumes: tasks are called by the bench between clock edges
// Notes: once latched the lines show the inverse byte, so a leaky latch shows
`timescale 1ns/10ps
module hpp_periph
(
  input wire logic i_clk,
  output logic [7:0] o_lines,
  output logic o_strobe_n,
  output logic o_ack_n
);
  initial
  begin
    o_lines = 8'h00;
    o_strobe_n = 1'b1;
    o_ack_n = 1'b0;
  end
  task automatic send(input logic [7:0] d, input logic latch);
    @(posedge i_clk);
    o_lines <= d;
    o_strobe_n <= 1'b1;
    @(posedge i_clk);
    o_strobe_n <= !latch;
    @(posedge i_clk);
    if (latch)
      o_lines <= ~d;
  endtask : send
  task automatic set_ack(input logic v);
    @(posedge i_clk);
    o_ack_n <= v;
  endtask : set_ack
endmodule : hpp_periph

// *** tb/hpp_port_sva.sv ***
// Purpose: port checks for the handshake parallel port
// Assumes: one clock, asynchronous active-low reset
// Notes: same-edge races the hand-over leaves open are excluded
`timescale 1ns/10ps
module hpp_port_chk
(
  input wire logic i_clk, i_arst_n, i_rd, i_wr, i_ack_n, i_drive_always,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata, i_input_data_lines, o_output_data_lines,
  input wire logic i_input_latch_strobe_n, o_input_ready_n, o_output_drive_en,
  input wire logic o_output_data_valid_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire rdd = i_rd && !i_wr && i_addr == 4'hc;
  wire rds = i_rd && !i_wr && i_addr == 4'hd;
  wire wrd = i_wr && i_addr == 4'hc;
  rd_ready_a: assert property (rdd |=> o_input_ready_n)
    else $error("ready not raised by read");
  stat_bits_a: assert property (rds |=> o_rdata[7:2] ==
    {4'h0, $past(i_input_latch_strobe_n), $past(i_ack_n)} &&
    o_rdata[0] == $past(o_output_data_valid_n)) else $error("status bits wrong");
  strobe_fall_a: assert property ($fell(i_input_latch_strobe_n) |=> o_input_ready_n)
    else $error("ready not raised by strobe");
  read_end_a: assert property ($fell(i_rd) && $past(rdd) &&
    !$fell(i_input_latch_strobe_n) |=> !o_input_ready_n) else $error("ready stuck");
  live_data_a: assert property (rdd && $past(i_input_latch_strobe_n) &&
    $past(i_arst_n) |=> o_rdata == $past(i_input_data_lines, 2)) else $error("read data");
  write_end_a: assert property ($fell(i_wr) && $past(i_addr) == 4'hc &&
    !$fell(i_ack_n) |=> !o_output_data_valid_n) else $error("valid not asserted");
  write_pulse_a: assert property (wrd |=> o_output_data_valid_n &&
    o_output_data_lines == $past(i_wdata)) else $error("write load");
  ack_fall_a: assert property ($fell(i_ack_n) && !i_wr && !$past(i_wr) |=>
    o_output_data_valid_n) else $error("valid not released");
  drive_en_a: assert property (1 |=> o_output_drive_en ==
    ($past(i_drive_always) | $past(i_ack_n))) else $error("drive enable");
  cover property (rdd ##1 !i_rd);
  cover property (wrd ##1 !i_wr);
  cover property ($fell(i_ack_n));
endmodule : hpp_port_chk

bind hpp_port hpp_port_chk u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_rd(i_rd),
  .i_wr(i_wr), .i_ack_n(i_ack_n), .i_drive_always(i_drive_always), .i_addr(i_addr),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .i_input_data_lines(i_input_data_lines),
  .o_output_data_lines(o_output_data_lines), .o_input_ready_n(o_input_ready_n),
  .i_input_latch_strobe_n(i_input_latch_strobe_n), .o_output_drive_en(o_output_drive_en),
  .o_output_data_valid_n(o_output_data_valid_n));

// *** tb/tb.sv ***
// Purpose: self-checking bench for the handshake parallel port
// Assumes: read data settles one cycle after the read edge
// Notes: waits are fixed by the hand-over timing, a watchdog cuts hangs
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_rd = 1'b0, i_wr = 1'b0, i_drive_always = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, lines, dout, d;
  logic strobe_n, ack_n, ready_n, drv_en, valid_n;
  int mismatches = 0, total_checks = 0;
  always #25 i_clk = ~i_clk;
  hpp_periph u_per (.i_clk(i_clk), .o_lines(lines), .o_strobe_n(strobe_n), .o_ack_n(ack_n));
  hpp_port u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_rd(i_rd),
    .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_input_data_lines(lines),
    .i_input_latch_strobe_n(strobe_n), .o_input_ready_n(ready_n),
    .o_output_data_lines(dout), .o_output_drive_en(drv_en),
    .o_output_data_valid_n(valid_n), .i_ack_n(ack_n), .i_drive_always(i_drive_always));
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask : rd
  task automatic wr(input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= 4'hc;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic sc_reset;
    `CHK("ready", 1'b0, ready_n)
    rd(4'hd);
    `CHK("status", 8'h09, d)
  endtask : sc_reset
  task automatic sc_input;
    u_per.send(8'ha5, 1'b1);
    settle(1);
    `CHK("ready", 1'b1, ready_n)
    rd(4'hd);
    `CHK("status", 8'h02, d & 8'h0a)
    rd(4'hc);
    `CHK("data", 8'ha5, d)
    settle(2);
    `CHK("ready", 1'b0, ready_n)
  endtask : sc_input
  task automatic sc_transparent;
    u_per.send(8'h3c, 1'b0);
    rd(4'hc);
    `CHK("ready", 1'b1, ready_n)
    `CHK("data", 8'h3c, d)
  endtask : sc_transparent
  task automatic sc_output;
    wr(8'h5a);
    settle(2);
    `CHK("valid", 1'b0, valid_n)
    `CHK("dout", 8'h5a, dout)
    u_per.set_ack(1'b1);
    settle(1);
    `CHK("drive", 1'b1, drv_en)
    rd(4'hd);
    `CHK("status", 8'h04, d & 8'h05)
    u_per.set_ack(1'b0);
    settle(1);
    `CHK("valid", 1'b1, valid_n)
    `CHK("drive", 1'b0, drv_en)
  endtask : sc_output
  task automatic sc_direct;
    @(posedge i_clk);
    i_drive_always <= 1'b1;
    u_per.set_ack(1'b1);
    wr(8'h11);
    settle(2);
    wr(8'hc3);
    @(negedge i_clk);
    `CHK("valid", 1'b1, valid_n)
    `CHK("dout", 8'hc3, dout)
    settle(2);
    `CHK("valid", 1'b0, valid_n)
    u_per.set_ack(1'b0);
    settle(1);
    `CHK("drive", 1'b1, drv_en)
  endtask : sc_direct
  task automatic conclude;
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    settle(1);
    sc_reset;
    sc_input;
    sc_transparent;
    sc_output;
    sc_direct;
    conclude;
  end
  initial
  begin
    repeat (2000) @(posedge i_clk);
    mismatches++;
    conclude;
  end
endmodule : tb
